// ===== phyx_dev_end.sv
// device end of the mac-facing media independent link
`timescale 1ns/10ps
`default_nettype none
// Operation
// - mii receive valid marks each valid nibble
// - rmii combined valid, two low data lines
// - rgmii control: valid on rise, error fall
// - mii receive error on receive clock rise
// - rmii receive error on reference clock rise
// - device corrupts data on receive error
// - receive clock only in mii and rgmii
// - six-wire serial mode drives continuous clock
// - serial mode: data pairs, out and in
// - mii transmit clock driven by device
// - rgmii transmit clock comes from mac
// - mii transmit enable marks valid nibble
// - rmii transmit enable marks valid dibit
// - rgmii transmit control: enable rise, error fall
// - nibble or dibit set up before rise
// - transmit error only used in mii
// - mii and rgmii nibble on clock rise
// - rmii reference clock on top data line
module phyx_dev_end
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // mode selection, static while traffic runs
    input wire phyx_pkg::phyx_mode_e mode_i,
    input wire logic serial_clk_en_i,
    // nibbles from the line side toward the mac
    input wire logic rx_valid_i,
    input wire logic [3:0] rx_data_i,
    input wire logic rx_err_i,
    output logic rx_take_o,
    // nibbles from the mac toward the line side
    output logic tx_valid_o,
    output logic [3:0] tx_data_o,
    output logic tx_err_o,
    // mac link
    phyx_link_if.dev link
);
    import phyx_pkg::*;

    logic [CNT_W-1:0] cnt_q;
    logic lclk_q;
    logic lo1;
    logic hi1;
    logic smp;
    logic load;
    logic [3:0] fwd;
    logic [3:0] nib_q;
    logic dv_q;
    logic er_q;
    logic ctl_q;
    logic half_q;
    logic bit_q;
    logic [3:0] sh_q;
    logic [2:0] bits_q;
    logic take_q;
    logic [3:0] pd_q;
    logic pdv_q;
    logic per_q;
    logic pclk_q;
    logic ptxc_q;
    logic ptxc_oe_n_q;
    logic [6:0] s1_q;
    logic [6:0] s2_q;
    logic tcp_q;
    logic trise;
    logic tfall;
    logic [3:0] tnib_q;
    logic ten_q;
    logic thalf_q;
    logic [2:0] tbits_q;
    logic tvalid_q;
    logic [3:0] tdata_q;
    logic terr_q;

    // link clock divider
    always_ff @(posedge core_clk_i)
    begin
        if (!reset_n_i)
        begin
            cnt_q <= CNT_ZERO;
            lclk_q <= 1'b0;
        end
        else if (cnt_q == HALF_LAST)
        begin
            cnt_q <= CNT_ZERO;
            lclk_q <= !lclk_q;
        end
        else
        begin
            cnt_q <= cnt_q + 3'h1;
        end
    end

    assign lo1 = !lclk_q && cnt_q == CNT_ZERO;
    assign hi1 = lclk_q && cnt_q == CNT_ZERO;
    assign smp = lclk_q && cnt_q == SMP_CNT;
    assign fwd = rx_err_i ? ~rx_data_i : rx_data_i;

    // when a new receive symbol is taken
    always_comb
    begin
        case (mode_i)
            PHYX_RMII: load = lo1 && !half_q;
            PHYX_SGMII: load = lo1 && bits_q == BITS_ZERO;
            default: load = lo1;
        endcase
    end

    // receive symbol hold
    always_ff @(posedge core_clk_i)
    begin
        if (!reset_n_i)
        begin
            take_q <= 1'b0;
            nib_q <= NIB_ZERO;
            dv_q <= 1'b0;
            er_q <= 1'b0;
        end
        else
        begin
            take_q <= load && rx_valid_i;
            if (load)
            begin
                nib_q <= rx_valid_i ? fwd : NIB_ZERO;
                dv_q <= rx_valid_i;
                er_q <= rx_valid_i && rx_err_i;
            end
        end
    end

    // rmii dibit phase and rgmii control phase
    always_ff @(posedge core_clk_i)
    begin
        if (!reset_n_i)
        begin
            half_q <= 1'b0;
            ctl_q <= 1'b0;
        end
        else
        begin
            if (lo1 && mode_i == PHYX_RMII)
            begin
                half_q <= !half_q && rx_valid_i;
            end
            if (lo1)
            begin
                ctl_q <= rx_valid_i;
            end
            else if (hi1)
            begin
                ctl_q <= er_q;
            end
        end
    end

    // serial framing: marker bit then four data bits
    always_ff @(posedge core_clk_i)
    begin
        if (!reset_n_i)
        begin
            bit_q <= 1'b0;
            sh_q <= NIB_ZERO;
            bits_q <= BITS_ZERO;
        end
        else if (lo1 && mode_i == PHYX_SGMII)
        begin
            if (bits_q == BITS_ZERO)
            begin
                bit_q <= rx_valid_i;
                sh_q <= fwd;
                bits_q <= rx_valid_i ? SER_BITS : BITS_ZERO;
            end
            else
            begin
                bit_q <= sh_q[0];
                sh_q <= sh_q >> 1;
                bits_q <= bits_q - 3'h1;
            end
        end
    end

    // pin registers, one cycle behind the divider
    always_ff @(posedge core_clk_i)
    begin
        if (!reset_n_i)
        begin
            pd_q <= NIB_ZERO;
            pdv_q <= 1'b0;
            per_q <= 1'b0;
            pclk_q <= 1'b0;
            ptxc_q <= 1'b0;
            ptxc_oe_n_q <= 1'b1;
        end
        else
        begin
            pclk_q <= (mode_i == PHYX_MII || mode_i == PHYX_RGMII) && lclk_q;
            ptxc_q <= mode_i == PHYX_MII && lclk_q;
            ptxc_oe_n_q <= mode_i != PHYX_MII;
            case (mode_i)
                PHYX_RMII:
                begin
                    pd_q <= {lclk_q, 1'b0, half_q ? nib_q[1:0] : nib_q[3:2]};
                    pdv_q <= dv_q;
                    per_q <= er_q;
                end
                PHYX_RGMII:
                begin
                    pd_q <= nib_q;
                    pdv_q <= ctl_q;
                    per_q <= 1'b0;
                end
                PHYX_SGMII:
                begin
                    pd_q[3:2] <= {~bit_q, bit_q};
                    pd_q[1:0] <= serial_clk_en_i ? {~lclk_q, lclk_q} : 2'b00;
                    pdv_q <= 1'b0;
                    per_q <= 1'b0;
                end
                default:
                begin
                    pd_q <= nib_q;
                    pdv_q <= dv_q;
                    per_q <= er_q;
                end
            endcase
        end
    end

    // synchronise mac-driven pins
    always_ff @(posedge core_clk_i)
    begin
        if (!reset_n_i)
        begin
            s1_q <= 7'h00;
            s2_q <= 7'h00;
            tcp_q <= 1'b0;
        end
        else
        begin
            s1_q <= {link.tx_clk, link.tx_er, link.tx_en, link.tx_d};
            s2_q <= s1_q;
            tcp_q <= s2_q[6];
        end
    end

    assign trise = s2_q[6] && !tcp_q;
    assign tfall = !s2_q[6] && tcp_q;

    // transmit capture and pairing
    always_ff @(posedge core_clk_i)
    begin
        if (!reset_n_i)
        begin
            tvalid_q <= 1'b0;
            tdata_q <= NIB_ZERO;
            terr_q <= 1'b0;
            tnib_q <= NIB_ZERO;
            ten_q <= 1'b0;
            thalf_q <= 1'b0;
            tbits_q <= BITS_ZERO;
        end
        else
        begin
            tvalid_q <= 1'b0;
            case (mode_i)
                PHYX_MII:
                begin
                    if (smp && s2_q[4])
                    begin
                        tvalid_q <= 1'b1;
                        tdata_q <= s2_q[3:0];
                        terr_q <= s2_q[5];
                    end
                end
                PHYX_RMII:
                begin
                    if (smp && s2_q[4] && !thalf_q)
                    begin
                        tnib_q[1:0] <= s2_q[1:0];
                        thalf_q <= 1'b1;
                    end
                    else if (smp && s2_q[4])
                    begin
                        tvalid_q <= 1'b1;
                        tdata_q <= {s2_q[1:0], tnib_q[1:0]};
                        terr_q <= 1'b0;
                        thalf_q <= 1'b0;
                    end
                    else if (smp)
                    begin
                        thalf_q <= 1'b0;
                    end
                end
                PHYX_RGMII:
                begin
                    if (trise)
                    begin
                        ten_q <= s2_q[4];
                        tnib_q <= s2_q[3:0];
                    end
                    else if (tfall && ten_q)
                    begin
                        tvalid_q <= 1'b1;
                        tdata_q <= tnib_q;
                        terr_q <= s2_q[4];
                    end
                end
                PHYX_SGMII:
                begin
                    if (smp && tbits_q == BITS_ZERO && s2_q[1])
                    begin
                        tbits_q <= SER_BITS;
                    end
                    else if (smp && tbits_q != BITS_ZERO)
                    begin
                        tnib_q <= {s2_q[1], tnib_q[3:1]};
                        tbits_q <= tbits_q - 3'h1;
                        if (tbits_q == BITS_LAST)
                        begin
                            tvalid_q <= 1'b1;
                            tdata_q <= {s2_q[1], tnib_q[3:1]};
                            terr_q <= 1'b0;
                        end
                    end
                end
                default:
                begin
                end
            endcase
        end
    end

    assign rx_take_o = take_q;
    assign tx_valid_o = tvalid_q;
    assign tx_data_o = tdata_q;
    assign tx_err_o = terr_q;
    assign link.rx_d = pd_q;
    assign link.rx_dv = pdv_q;
    assign link.rx_er = per_q;
    assign link.rx_clk = pclk_q;
    assign link.tx_clk_dev = ptxc_q;
    assign link.tx_clk_dev_oe_n = ptxc_oe_n_q;
endmodule // phyx_dev_end
`default_nettype wire

// ===== phyx_pkg.sv
// shared constants and types of the mac-facing link
package phyx_pkg;
    typedef enum logic [1:0] {PHYX_MII, PHYX_RMII, PHYX_RGMII, PHYX_SGMII} phyx_mode_e;
    localparam int CLK_PERIOD_NS = 20;
    // link clock period that both ends generate and expect
    localparam int LINK_PERIOD_NS = 160;
    localparam int HALF_CYC = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam int CNT_W = 3;
    localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
    localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HALF_CYC - 1);
    localparam int SYNC_DEPTH = 2;
    // own sample point: pin register plus synchroniser
    localparam logic [CNT_W-1:0] SMP_CNT = CNT_W'(1 + SYNC_DEPTH);
    // data of a generated clock moves one cycle into a phase
    localparam logic [CNT_W-1:0] DRV_CNT = 3'h1;
    localparam logic [2:0] SER_BITS = 3'h4;
    localparam logic [2:0] BITS_ZERO = 3'h0;
    localparam logic [2:0] BITS_LAST = 3'h1;
    localparam logic [3:0] NIB_ZERO = 4'h0;
endpackage

// ===== phyx_link_if.sv
// pins between the device end and the mac end
`timescale 1ns/10ps
`default_nettype none
interface phyx_link_if;
    logic [3:0] rx_d;
    logic rx_dv;
    logic rx_er;
    logic rx_clk;
    logic [3:0] tx_d;
    logic tx_en;
    logic tx_er;
    logic tx_clk_dev;
    logic tx_clk_dev_oe_n;
    logic tx_clk_mac;
    logic tx_clk_mac_oe_n;
    logic tx_clk;
    // two-way transmit clock, pulled down when nobody drives
    assign tx_clk = !tx_clk_dev_oe_n ? tx_clk_dev : (!tx_clk_mac_oe_n ? tx_clk_mac : 1'b0);
    modport dev
    (
        output rx_d, rx_dv, rx_er, rx_clk, tx_clk_dev, tx_clk_dev_oe_n,
        input tx_d, tx_en, tx_er, tx_clk
    );
    modport mac
    (
        input rx_d, rx_dv, rx_er, rx_clk, tx_clk,
        output tx_d, tx_en, tx_er, tx_clk_mac, tx_clk_mac_oe_n
    );
endinterface
`default_nettype wire

// ===== phyx_mac_end.sv
// mac end of the media independent link
`timescale 1ns/10ps
`default_nettype none
module phyx_mac_end
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // mode selection, static while traffic runs
    input wire phyx_pkg::phyx_mode_e mode_i,
    // nibbles to send toward the device
    input wire logic tx_valid_i,
    input wire logic [3:0] tx_data_i,
    input wire logic tx_err_i,
    output logic tx_take_o,
    // nibbles received from the device
    output logic rx_valid_o,
    output logic [3:0] rx_data_o,
    output logic rx_err_o,
    // device link
    phyx_link_if.mac link
);
    import phyx_pkg::*;

    logic [CNT_W-1:0] cnt_q;
    logic lclk_q;
    logic [7:0] s1_q;
    logic [7:0] s2_q;
    logic [7:0] p_q;
    logic [7:0] rise;
    logic [7:0] fall;
    logic drv;
    logic hi2;
    logic load;
    logic [3:0] txd_q;
    logic txen_q;
    logic txer_q;
    logic [3:0] nib_q;
    logic ter_q;
    logic half_q;
    logic [2:0] bits_q;
    logic take_q;
    logic tclk_q;
    logic tclk_oe_n_q;
    logic [3:0] rnib_q;
    logic rdv_q;
    logic rer_q;
    logic rhalf_q;
    logic [2:0] rbits_q;
    logic rvalid_q;
    logic [3:0] rdata_q;
    logic rerr_q;

    // own divider for the rgmii transmit clock
    always_ff @(posedge core_clk_i)
    begin
        if (!reset_n_i)
        begin
            cnt_q <= CNT_ZERO;
            lclk_q <= 1'b0;
        end
        else if (cnt_q == HALF_LAST)
        begin
            cnt_q <= CNT_ZERO;
            lclk_q <= !lclk_q;
        end
        else
        begin
            cnt_q <= cnt_q + 3'h1;
        end
    end

    // synchronise device-driven pins
    always_ff @(posedge core_clk_i)
    begin
        if (!reset_n_i)
        begin
            s1_q <= 8'h00;
            s2_q <= 8'h00;
            p_q <= 8'h00;
        end
        else
        begin
            s1_q <= {link.tx_clk, link.rx_clk, link.rx_er, link.rx_dv, link.rx_d};
            s2_q <= s1_q;
            p_q <= s2_q;
        end
    end

    assign rise = s2_q & ~p_q;
    assign fall = ~s2_q & p_q;
    assign hi2 = lclk_q && cnt_q == DRV_CNT;

    // drive point of each mode
    always_comb
    begin
        case (mode_i)
            PHYX_RMII: drv = fall[3];
            PHYX_RGMII: drv = !lclk_q && cnt_q == DRV_CNT;
            PHYX_SGMII: drv = fall[0];
            default: drv = fall[7];
        endcase
        case (mode_i)
            PHYX_RMII: load = drv && !half_q;
            PHYX_SGMII: load = drv && bits_q == BITS_ZERO;
            default: load = drv;
        endcase
    end

    // transmit pins
    always_ff @(posedge core_clk_i)
    begin
        if (!reset_n_i)
        begin
            take_q <= 1'b0;
            txd_q <= NIB_ZERO;
            txen_q <= 1'b0;
            txer_q <= 1'b0;
            nib_q <= NIB_ZERO;
            ter_q <= 1'b0;
            half_q <= 1'b0;
            bits_q <= BITS_ZERO;
            tclk_q <= 1'b0;
            tclk_oe_n_q <= 1'b1;
        end
        else
        begin
            take_q <= load && tx_valid_i;
            tclk_q <= mode_i == PHYX_RGMII && lclk_q;
            tclk_oe_n_q <= mode_i != PHYX_RGMII;
            case (mode_i)
                PHYX_MII:
                begin
                    if (drv)
                    begin
                        txen_q <= tx_valid_i;
                        txd_q <= tx_data_i;
                        txer_q <= tx_valid_i && tx_err_i;
                    end
                end
                PHYX_RMII:
                begin
                    if (load)
                    begin
                        txen_q <= tx_valid_i;
                        nib_q <= tx_data_i;
                        txd_q <= {2'b00, tx_data_i[1:0]};
                        half_q <= tx_valid_i;
                    end
                    else if (drv)
                    begin
                        txd_q <= {2'b00, nib_q[3:2]};
                        half_q <= 1'b0;
                    end
                end
                PHYX_RGMII:
                begin
                    if (drv)
                    begin
                        txen_q <= tx_valid_i;
                        txd_q <= tx_data_i;
                        ter_q <= tx_valid_i && tx_err_i;
                    end
                    else if (hi2)
                    begin
                        txen_q <= ter_q;
                    end
                end
                PHYX_SGMII:
                begin
                    if (load)
                    begin
                        txd_q <= {2'b00, tx_valid_i, !tx_valid_i};
                        nib_q <= tx_data_i;
                        bits_q <= tx_valid_i ? SER_BITS : BITS_ZERO;
                    end
                    else if (drv)
                    begin
                        txd_q <= {2'b00, nib_q[0], !nib_q[0]};
                        nib_q <= nib_q >> 1;
                        bits_q <= bits_q - 3'h1;
                    end
                end
                default:
                begin
                end
            endcase
        end
    end

    // receive capture and pairing
    always_ff @(posedge core_clk_i)
    begin
        if (!reset_n_i)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= NIB_ZERO;
            rerr_q <= 1'b0;
            rnib_q <= NIB_ZERO;
            rdv_q <= 1'b0;
            rer_q <= 1'b0;
            rhalf_q <= 1'b0;
            rbits_q <= BITS_ZERO;
        end
        else
        begin
            rvalid_q <= 1'b0;
            case (mode_i)
                PHYX_MII:
                begin
                    if (rise[6] && s2_q[4])
                    begin
                        rvalid_q <= 1'b1;
                        rdata_q <= s2_q[3:0];
                        rerr_q <= s2_q[5];
                    end
                end
                PHYX_RMII:
                begin
                    if (rise[3] && s2_q[4] && !rhalf_q)
                    begin
                        rnib_q[1:0] <= s2_q[1:0];
                        rer_q <= s2_q[5];
                        rhalf_q <= 1'b1;
                    end
                    else if (rise[3] && s2_q[4])
                    begin
                        rvalid_q <= 1'b1;
                        rdata_q <= {s2_q[1:0], rnib_q[1:0]};
                        rerr_q <= rer_q || s2_q[5];
                        rhalf_q <= 1'b0;
                    end
                    else if (rise[3])
                    begin
                        rhalf_q <= 1'b0;
                    end
                end
                PHYX_RGMII:
                begin
                    if (rise[6])
                    begin
                        rdv_q <= s2_q[4];
                        rnib_q <= s2_q[3:0];
                    end
                    else if (fall[6] && rdv_q)
                    begin
                        rvalid_q <= 1'b1;
                        rdata_q <= rnib_q;
                        rerr_q <= s2_q[4];
                    end
                end
                PHYX_SGMII:
                begin
                    if (rise[0] && rbits_q == BITS_ZERO && s2_q[2])
                    begin
                        rbits_q <= SER_BITS;
                    end
                    else if (rise[0] && rbits_q != BITS_ZERO)
                    begin
                        rnib_q <= {s2_q[2], rnib_q[3:1]};
                        rbits_q <= rbits_q - 3'h1;
                        if (rbits_q == BITS_LAST)
                        begin
                            rvalid_q <= 1'b1;
                            rdata_q <= {s2_q[2], rnib_q[3:1]};
                            rerr_q <= 1'b0;
                        end
                    end
                end
                default:
                begin
                end
            endcase
        end
    end

    assign tx_take_o = take_q;
    assign rx_valid_o = rvalid_q;
    assign rx_data_o = rdata_q;
    assign rx_err_o = rerr_q;
    assign link.tx_d = txd_q;
    assign link.tx_en = txen_q;
    assign link.tx_er = txer_q;
    assign link.tx_clk_mac = tclk_q;
    assign link.tx_clk_mac_oe_n = tclk_oe_n_q;
endmodule // phyx_mac_end
`default_nettype wire

// ===== phyx_link_assertions.sv
// pin-level checks on the link between the two ends
`timescale 1ns/10ps
`default_nettype none
module phyx_link_assertions
(
    // clock, reset and mode
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire phyx_pkg::phyx_mode_e mode_i,
    input wire logic serial_clk_en_i,
    // link pins
    input wire logic [3:0] rx_d,
    input wire logic rx_dv,
    input wire logic rx_er,
    input wire logic rx_clk,
    input wire logic [3:0] tx_d,
    input wire logic tx_en,
    input wire logic tx_er,
    input wire logic tx_clk,
    input wire logic tx_clk_dev_oe_n,
    input wire logic tx_clk_mac_oe_n
);
    import phyx_pkg::*;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!reset_n_i);
    // one generated link period: four high, four low
    sequence link_wave(s);
        (s)[*4] ##1 !(s)[*4];
    endsequence
    AST_RX_CLK_WAVE: assert property ($rose(rx_clk)
        && mode_i inside {PHYX_MII, PHYX_RGMII}
        |-> link_wave(rx_clk)) else $error("receive clock period wrong");
    AST_RMII_REF_WAVE: assert property ($rose(rx_d[3]) && mode_i == PHYX_RMII
        |-> link_wave(rx_d[3])) else $error("reference clock period wrong");
    AST_RX_CLK_IDLE: assert property (mode_i inside {PHYX_RMII, PHYX_SGMII}
        |-> !rx_clk) else $error("receive clock active");
    AST_TX_ER_IDLE: assert property (mode_i != PHYX_MII |-> !tx_er)
        else $error("transmit error driven");
    AST_MII_TX_CLK: assert property ($past(reset_n_i) && mode_i == PHYX_MII
        |-> !tx_clk_dev_oe_n && tx_clk_mac_oe_n) else $error("wrong transmit clock owner");
    AST_RGMII_TX_CLK: assert property ($past(reset_n_i) && mode_i == PHYX_RGMII
        |-> tx_clk_dev_oe_n && !tx_clk_mac_oe_n) else $error("wrong transmit clock owner");
    AST_SGMII_QUIET: assert property (mode_i == PHYX_SGMII |-> !rx_dv && !rx_er)
        else $error("parallel receive pins active");
    AST_SERIAL_CLK_OFF: assert property (mode_i == PHYX_SGMII && !serial_clk_en_i
        |-> rx_d[1:0] == 2'h0) else $error("serial clock pair active");
    AST_RMII_UNUSED: assert property (mode_i == PHYX_RMII
        |-> !rx_d[2] && tx_d[3:2] == 2'h0) else $error("unused data lines driven");
    AST_MII_RX_HOLD: assert property (mode_i == PHYX_MII && rx_clk && $past(rx_clk)
        |-> $stable(rx_d) && $stable(rx_dv) && $stable(rx_er)) else $error("receive pins moved");
    AST_MII_TX_HOLD: assert property (mode_i == PHYX_MII && tx_clk && $past(tx_clk)
        |-> $stable(tx_d) && $stable(tx_en) && $stable(tx_er)) else $error("transmit pins moved");
endmodule // phyx_link_assertions
`default_nettype wire

// ===== phy_xmii_mac_side_interface_test.sv
// random two-way traffic through both ends in every mode
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e, m) begin check_count++; if ((g) !== (e)) \
    begin failures++; $display("CHECK FAILED %0t %s", $time, m); end end
module phy_xmii_mac_side_interface_test;
    import phyx_pkg::*;
    logic core_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    phyx_mode_e mode_i = PHYX_MII;
    logic serial_clk_en_i = 1'b1;
    // index 0: device receive toward mac, 1: mac transmit toward device
    logic src_valid[2] = '{1'b0, 1'b0};
    logic [3:0] src_data[2] = '{4'h0, 4'h0};
    logic src_err[2] = '{1'b0, 1'b0};
    logic take[2];
    logic got_v[2];
    logic [3:0] got_d[2];
    logic got_e[2];
    logic [4:0] exp_q[2][$];
    int failures = 0;
    int check_count = 0;
    int cycles = 0;
    int w;
    logic [4:0] exp_v;
    phyx_link_if link ();
    phyx_dev_end phyx_dev_end_inst
    (
        .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .mode_i(mode_i),
        .serial_clk_en_i(serial_clk_en_i), .rx_valid_i(src_valid[0]), .rx_data_i(src_data[0]),
        .rx_err_i(src_err[0]), .rx_take_o(take[0]), .tx_valid_o(got_v[1]),
        .tx_data_o(got_d[1]), .tx_err_o(got_e[1]), .link(link.dev)
    );
    phyx_mac_end phyx_mac_end_inst
    (
        .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .mode_i(mode_i),
        .tx_valid_i(src_valid[1]), .tx_data_i(src_data[1]), .tx_err_i(src_err[1]),
        .tx_take_o(take[1]), .rx_valid_o(got_v[0]), .rx_data_o(got_d[0]),
        .rx_err_o(got_e[0]), .link(link.mac)
    );
    phyx_link_assertions phyx_link_assertions_inst
    (
        .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .mode_i(mode_i),
        .serial_clk_en_i(serial_clk_en_i), .rx_d(link.rx_d), .rx_dv(link.rx_dv),
        .rx_er(link.rx_er), .rx_clk(link.rx_clk), .tx_d(link.tx_d), .tx_en(link.tx_en),
        .tx_er(link.tx_er), .tx_clk(link.tx_clk), .tx_clk_dev_oe_n(link.tx_clk_dev_oe_n),
        .tx_clk_mac_oe_n(link.tx_clk_mac_oe_n)
    );
    initial
    begin
        forever #10 core_clk_i = ~core_clk_i;
    end
    // receive side corrupts the nibble by inversion on error
    function automatic logic [4:0] expect_nib(input logic [3:0] d, input logic e, input logic inv);
        return (e && inv) ? {1'b1, ~d} : {e, d};
    endfunction
    function automatic logic [4:0] pop(input int k);
        return (exp_q[k].size() != 0) ? exp_q[k].pop_front() : {5{1'bx}};
    endfunction
    task automatic send(input int k, input int n, input logic err_ok);
        logic [3:0] d;
        logic e;
        int t;
        for (int i = 0; i < n; i++)
        begin
            d = (i == 0) ? 4'hF : ((i == 1) ? 4'h0 : 4'($urandom));
            e = err_ok && ($urandom_range(3) == 0);
            exp_q[k].push_back(expect_nib(d, e, k == 0));
            src_valid[k] <= 1'b1;
            src_data[k] <= d;
            src_err[k] <= e;
            t = 0;
            do
            begin
                @(posedge core_clk_i);
                t++;
            end
            while (take[k] !== 1'b1 && t < 400);
            `CHK(t < 400, 1'b1, "nibble never taken")
        end
        src_valid[k] <= 1'b0;
    endtask
    task automatic finish_test();
        if (failures == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge core_clk_i)
    begin
        for (int k = 0; k < 2; k++)
        begin
            if (reset_n_i === 1'b1 && got_v[k] === 1'b1)
            begin
                exp_v = pop(k);
                `CHK(got_d[k], exp_v[3:0], "nibble differs")
                `CHK(got_e[k], exp_v[4], "error flag differs")
            end
        end
    end
    always @(posedge core_clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            finish_test();
        end
    end
    initial
    begin
        void'($urandom(32'h2F36));
        for (int m = 0; m < 5; m++)
        begin
            reset_n_i <= 1'b0;
            mode_i <= phyx_mode_e'(m < 4 ? m : 3);
            serial_clk_en_i <= (m < 4);
            repeat (4) @(posedge core_clk_i);
            reset_n_i <= 1'b1;
            @(posedge core_clk_i);
            fork
                send(0, (m < 4) ? 12 : 0, m < 3);
                send(1, (m < 4) ? 12 : 0, m == 0);
            join
            w = 0;
            while (exp_q[0].size() + exp_q[1].size() != 0 && w < 2000)
            begin
                @(posedge core_clk_i);
                w++;
            end
            repeat (40) @(posedge core_clk_i);
            `CHK(exp_q[0].size() + exp_q[1].size(), 0, "nibbles lost")
        end
        finish_test();
    end
endmodule // phy_xmii_mac_side_interface_test
`default_nettype wire
